// ===== src/gcb_bank.sv
// Global system control register bank with an AXI4-Lite slave port.
`timescale 1ns/1ps
`include "gcb_defines.svh"

// What this block does
// R1: Only system or power-on reset clears bank.
// R2: Bit 15 reports checksum pass or fail.
// R3: Result valid only after start bit clears.
// R4: Writing 1 to bit 13 starts checksum.
// R5: Writing 0 to start bit does nothing.
// R6: Completion clears start bit, updates result.
// R7: Bit 14 gates serial wire debug.
// R8: Debug bit writable only while lock unprogrammed.
// R9: Status at 0x40, interrupt enable 0x54.
// R10: Clock gates 0x24, 0x48; divisor 0x18.
// R11: Control bits 31..16 read zero, ignore writes.
module gcb_bank import gcb_pkg::*; #(
   parameter int ROM_AW = 8,
   parameter logic [31:0] EXPECTED_SUM = 32'h0000_0000,
   parameter logic [31:0] REVISION = 32'h0000_00A1 // Arbitrary value.
) (
   input wire logic mclk, // Core clock, 250 MHz.
   input wire logic rst_b, // System or power-on reset, active low.
   input wire logic ce, // Clock enable; low freezes all state.
   input wire gcb_axi_req_t axiReq, // AXI4-Lite requests from the master.
   output gcb_axi_rsp_t axiRsp, // AXI4-Lite answers to the master.
   input wire logic debugLockPin, // High once the debug lock word is programmed.
   input wire logic [31:0] romData, // ROM word at romAddr, same clock.
   output logic [ROM_AW-1:0] romAddr, // ROM word address for the checksum.
   output gcb_ctrl_t ctrl, // Register contents that steer the chip.
   output logic irq // Level interrupt, high while an enabled event is pending.
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic lockMeta;
      logic lockSync;
      logic awFull;
      logic [7:0] awAddr;
      logic wFull;
      logic [31:0] wData;
      logic [3:0] wStrb;
      gcb_axi_rsp_t rsp;
      gcb_ctrl_t ctrl;
      logic [31:0] sysSt;
      logic [31:0] sysIe;
      logic ckStart;
      logic irq;
   } gcb_state_t;

   localparam gcb_ctrl_t CTRL_RST = '{sysCtrl: `GCB_SC_RESET, default: 32'h0000_0000};
   localparam gcb_axi_rsp_t RSP_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
                                       default: '0};
   localparam gcb_state_t ST_RST = '{rsp: RSP_RST, ctrl: CTRL_RST, default: '0};

   gcb_state_t s_q;
   gcb_state_t s_d;
   logic ckDone;
   logic ckFail;

   gcb_checksum #(
      .ROM_AW(ROM_AW),
      .EXPECTED_SUM(EXPECTED_SUM)
   ) u_checksum (
      .mclk(mclk),
      .rst_b(rst_b),
      .ce(ce),
      .start(s_q.ckStart),
      .romData(romData),
      .romAddr(romAddr),
      .done(ckDone),
      .fail(ckFail)
   );

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [31:0] strbMask(input logic [3:0] strb);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{strb[i]}};
      end
      return m;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [31:0] m);
      return (old & ~m) | (wd & m);
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      unique case (a)
         `GCB_OFS_SYSCTRL, `GCB_OFS_RST0, `GCB_OFS_CLKCTRL, `GCB_OFS_PM,
         `GCB_OFS_PCLKDIV, `GCB_OFS_PCLKGATE0, `GCB_OFS_MEMCTRL, `GCB_OFS_MEMZ,
         `GCB_OFS_SYSST, `GCB_OFS_RST1, `GCB_OFS_PCLKGATE1, `GCB_OFS_EVENTEN,
         `GCB_OFS_REVISION, `GCB_OFS_SYSIE: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   // ****************************************************************
   // Next state
   // ****************************************************************
   logic [31:0] m;
   logic [31:0] wd;
   logic [31:0] sc;
   logic [31:0] rd;
   logic [31:0] evSet;
   logic [31:0] evClr;

   always_comb begin
      s_d = s_q;
      m = strbMask(s_q.wStrb);
      wd = s_q.wData;
      sc = s_q.ctrl.sysCtrl;
      rd = 32'h0000_0000;
      evSet = 32'h0000_0000;
      evClr = 32'h0000_0000;
      s_d.ckStart = 1'b0;

      // Debug lock pin crosses in through two flops; only the second is read.
      s_d.lockMeta = debugLockPin;
      s_d.lockSync = s_q.lockMeta;

      // The flush is treated as completing in one cycle.
      sc[`GCB_SC_FLUSH] = 1'b0;

      // Checksum completion clears start and records the outcome.
      if (ckDone) begin
         sc[`GCB_SC_CCHK] = 1'b0; // R6
         sc[`GCB_SC_CHKRES] = ckFail; // R2 R6
         evSet[`GCB_ST_CKDONE] = 1'b1;
         evSet[`GCB_ST_CKFAIL] = ckFail;
      end

      // Write channel: address and data may arrive in either order.
      if (axiReq.awvalid && s_q.rsp.awready) begin
         s_d.awFull = 1'b1;
         s_d.awAddr = axiReq.awaddr;
         s_d.rsp.awready = 1'b0;
      end
      if (axiReq.wvalid && s_q.rsp.wready) begin
         s_d.wFull = 1'b1;
         s_d.wData = axiReq.wdata;
         s_d.wStrb = axiReq.wstrb;
         s_d.rsp.wready = 1'b0;
      end

      if (s_q.awFull && s_q.wFull && !s_q.rsp.bvalid) begin
         s_d.awFull = 1'b0;
         s_d.wFull = 1'b0;
         s_d.rsp.bvalid = 1'b1;
         s_d.rsp.bresp = mapped(s_q.awAddr) ? `GCB_RESP_OKAY : `GCB_RESP_SLVERR;
         unique case (s_q.awAddr)
            `GCB_OFS_SYSCTRL: begin
               // Only the plain writable fields merge; 31..16 stay zero.
               sc = merge(sc, wd, m & `GCB_SC_WMASK); // R11
               if (m[`GCB_SC_SWDEN] && !s_q.lockSync) begin // R8
                  sc[`GCB_SC_SWDEN] = wd[`GCB_SC_SWDEN]; // R7
               end
               // A zero leaves a running sum and its result alone.
               if (m[`GCB_SC_CCHK] && wd[`GCB_SC_CCHK] && !s_q.ctrl.sysCtrl[`GCB_SC_CCHK]
                   && !ckDone) begin // R5
                  sc[`GCB_SC_CCHK] = 1'b1; // R4
                  s_d.ckStart = 1'b1; // R4
               end
            end
            `GCB_OFS_RST0: s_d.ctrl.rst0 = merge(s_q.ctrl.rst0, wd, m);
            `GCB_OFS_CLKCTRL: s_d.ctrl.clkCtrl = merge(s_q.ctrl.clkCtrl, wd, m);
            `GCB_OFS_PM: s_d.ctrl.pm = merge(s_q.ctrl.pm, wd, m);
            `GCB_OFS_PCLKDIV: s_d.ctrl.pclkDiv = merge(s_q.ctrl.pclkDiv, wd, m); // R10
            `GCB_OFS_PCLKGATE0: s_d.ctrl.pclkGate0 = merge(s_q.ctrl.pclkGate0, wd, m); // R10
            `GCB_OFS_MEMCTRL: s_d.ctrl.memCtrl = merge(s_q.ctrl.memCtrl, wd, m);
            `GCB_OFS_MEMZ: s_d.ctrl.memZ = merge(s_q.ctrl.memZ, wd, m);
            `GCB_OFS_SYSST: evClr = wd & m & `GCB_EV_MASK; // R9
            `GCB_OFS_RST1: s_d.ctrl.rst1 = merge(s_q.ctrl.rst1, wd, m);
            `GCB_OFS_PCLKGATE1: s_d.ctrl.pclkGate1 = merge(s_q.ctrl.pclkGate1, wd, m); // R10
            `GCB_OFS_EVENTEN: s_d.ctrl.eventEn = merge(s_q.ctrl.eventEn, wd, m);
            `GCB_OFS_SYSIE: s_d.sysIe = merge(s_q.sysIe, wd, m & `GCB_EV_MASK); // R9
            default: begin
            end
         endcase
      end
      if (s_q.rsp.bvalid && axiReq.bready) begin
         s_d.rsp.bvalid = 1'b0;
         s_d.rsp.bresp = `GCB_RESP_OKAY;
         s_d.rsp.awready = 1'b1;
         s_d.rsp.wready = 1'b1;
      end
      s_d.ctrl.sysCtrl = sc;

      // Status: events are sticky, a write of one clears, a new event wins.
      s_d.sysSt = ((s_q.sysSt & ~evClr) | evSet) & `GCB_EV_MASK;
      s_d.sysSt[`GCB_ST_LOCK] = s_q.lockSync;
      s_d.irq = |(s_d.sysSt & s_d.sysIe & `GCB_EV_MASK);

      // Read channel: one read at a time, answered on the next cycle.
      unique case (axiReq.araddr)
         `GCB_OFS_SYSCTRL: rd = s_q.ctrl.sysCtrl; // R2 R3 R11
         `GCB_OFS_RST0: rd = s_q.ctrl.rst0;
         `GCB_OFS_CLKCTRL: rd = s_q.ctrl.clkCtrl;
         `GCB_OFS_PM: rd = s_q.ctrl.pm;
         `GCB_OFS_PCLKDIV: rd = s_q.ctrl.pclkDiv; // R10
         `GCB_OFS_PCLKGATE0: rd = s_q.ctrl.pclkGate0; // R10
         `GCB_OFS_MEMCTRL: rd = s_q.ctrl.memCtrl;
         `GCB_OFS_MEMZ: rd = s_q.ctrl.memZ;
         `GCB_OFS_SYSST: rd = s_q.sysSt; // R9
         `GCB_OFS_RST1: rd = s_q.ctrl.rst1;
         `GCB_OFS_PCLKGATE1: rd = s_q.ctrl.pclkGate1; // R10
         `GCB_OFS_EVENTEN: rd = s_q.ctrl.eventEn;
         `GCB_OFS_REVISION: rd = REVISION;
         `GCB_OFS_SYSIE: rd = s_q.sysIe; // R9
         default: rd = 32'h0000_0000;
      endcase
      if (axiReq.arvalid && s_q.rsp.arready) begin
         s_d.rsp.arready = 1'b0;
         s_d.rsp.rvalid = 1'b1;
         s_d.rsp.rdata = rd;
         s_d.rsp.rresp = mapped(axiReq.araddr) ? `GCB_RESP_OKAY : `GCB_RESP_SLVERR;
      end else if (s_q.rsp.rvalid && axiReq.rready) begin
         s_d.rsp.rvalid = 1'b0;
         s_d.rsp.rdata = 32'h0000_0000;
         s_d.rsp.rresp = `GCB_RESP_OKAY;
         s_d.rsp.arready = 1'b1;
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   // The bank has no soft or peripheral reset input on purpose: only the
   // system and power-on reset reaches these flops.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= ST_RST; // R1
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign axiRsp = s_q.rsp;
   assign ctrl = s_q.ctrl;
   assign irq = s_q.irq;

endmodule // gcb_bank

// ===== src/gcb_checksum.sv
// ROM checksum engine: sums every ROM word and compares with the expected sum.
`timescale 1ns/1ps
`include "gcb_defines.svh"

module gcb_checksum import gcb_pkg::*; #(
   parameter int ROM_AW = 8,
   parameter logic [31:0] EXPECTED_SUM = 32'h0000_0000
) (
   input wire logic mclk, // Core clock.
   input wire logic rst_b, // Asynchronous reset, active low.
   input wire logic ce, // Clock enable.
   input wire logic start, // One-cycle start pulse.
   input wire logic [31:0] romData, // ROM word at romAddr.
   output logic [ROM_AW-1:0] romAddr, // ROM word address.
   output logic done, // One-cycle pulse when the sum is ready.
   output logic fail // Result of the last run, 1 on mismatch.
);

   typedef struct packed {
      gcb_ck_state_t st;
      logic [ROM_AW-1:0] addr;
      logic [31:0] sum;
      logic done;
      logic fail;
   } gcb_ck_t;

   localparam gcb_ck_t CK_RST = '{st: CK_IDLE, addr: '0, sum: 32'h0000_0000,
                                  done: 1'b0, fail: 1'b0};

   gcb_ck_t s_q;
   gcb_ck_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      unique case (s_q.st)
         CK_IDLE: begin
            if (start) begin
               s_d.st = CK_RUN;
               s_d.addr = '0;
               s_d.sum = 32'h0000_0000;
            end
         end
         CK_RUN: begin
            s_d.sum = s_q.sum + romData;
            if (s_q.addr == {ROM_AW{1'b1}}) begin
               s_d.st = CK_DONE;
            end else begin
               s_d.addr = s_q.addr + 1'b1;
            end
         end
         CK_DONE: begin
            s_d.done = 1'b1;
            s_d.fail = (s_q.sum != EXPECTED_SUM);
            s_d.st = CK_IDLE;
         end
         default: begin
            s_d.st = CK_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= CK_RST;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign romAddr = s_q.addr;
   assign done = s_q.done;
   assign fail = s_q.fail;

endmodule // gcb_checksum

// ===== src/gcb_defines.svh
// Offsets, field positions, reset values and codes of the global control bank.
`ifndef GCB_DEFINES_SVH
`define GCB_DEFINES_SVH

`define GCB_ADDR_W 8
`define GCB_OFS_SYSCTRL 8'h00
`define GCB_OFS_RST0 8'h04
`define GCB_OFS_CLKCTRL 8'h08
`define GCB_OFS_PM 8'h0C
`define GCB_OFS_PCLKDIV 8'h18
`define GCB_OFS_PCLKGATE0 8'h24
`define GCB_OFS_MEMCTRL 8'h28
`define GCB_OFS_MEMZ 8'h2C
`define GCB_OFS_SYSST 8'h40
`define GCB_OFS_RST1 8'h44
`define GCB_OFS_PCLKGATE1 8'h48
`define GCB_OFS_EVENTEN 8'h4C
`define GCB_OFS_REVISION 8'h50
`define GCB_OFS_SYSIE 8'h54

`define GCB_SC_CHKRES 15
`define GCB_SC_SWDEN 14
`define GCB_SC_CCHK 13
`define GCB_SC_FLUSH 6
`define GCB_SC_WMASK 32'h0000_0066
`define GCB_SC_RESET 32'h0000_0002

`define GCB_ST_LOCK 0
`define GCB_ST_CKDONE 1
`define GCB_ST_CKFAIL 2
`define GCB_EV_MASK 32'h0000_0006

`define GCB_RESP_OKAY 2'h0
`define GCB_RESP_SLVERR 2'h2

`endif

// ===== src/gcb_pkg.sv
// Types shared by the global control bank and its checksum engine.
package gcb_pkg;

   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } gcb_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } gcb_axi_rsp_t;

   typedef struct packed {
      logic [31:0] sysCtrl;
      logic [31:0] rst0;
      logic [31:0] clkCtrl;
      logic [31:0] pm;
      logic [31:0] pclkDiv;
      logic [31:0] pclkGate0;
      logic [31:0] memCtrl;
      logic [31:0] memZ;
      logic [31:0] rst1;
      logic [31:0] pclkGate1;
      logic [31:0] eventEn;
   } gcb_ctrl_t;

   typedef enum logic [1:0] {
      CK_IDLE = 2'b00,
      CK_RUN = 2'b01,
      CK_DONE = 2'b10
   } gcb_ck_state_t;

endpackage

// ===== tb/gcb_bank_asserts.sv
// Port-level checks of the global control bank.
`timescale 1ns/1ps
module gcb_bank_asserts import gcb_pkg::*; #(
   parameter int ROM_AW = 8
) (
   input wire logic mclk, // Core clock.
   input wire logic rst_b, // Reset, active low.
   input wire logic ce, // Clock enable.
   input wire gcb_axi_req_t axiReq, // Bus requests.
   input wire gcb_axi_rsp_t axiRsp, // Bus answers.
   input wire logic debugLockPin, // Debug lock level.
   input wire logic [31:0] romData, // ROM word.
   input wire logic [ROM_AW-1:0] romAddr, // ROM address.
   input wire gcb_ctrl_t ctrl, // Register contents.
   input wire logic irq // Interrupt.
);
   // ****************************************
   // Sequences and assertions
   // ****************************************
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sequence sRdTake; ce && axiReq.arvalid && axiRsp.arready; endsequence
   sequence sCkStart; $rose(ctrl.sysCtrl[13]); endsequence
   sequence sCkEnd; $fell(ctrl.sysCtrl[13]); endsequence
   // Five samples cover the two-flop synchroniser and the lock register.
   sequence sLocked; debugLockPin [*5]; endsequence
   function automatic logic mapped(logic [7:0] a);
      return a inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h18, 8'h24, 8'h28, 8'h2C, 8'h40,
         8'h44, 8'h48, 8'h4C, 8'h50, 8'h54};
   endfunction
   a_reset_values: assert property ($rose(rst_b) |-> ctrl == gcb_ctrl_t'({32'h2, 320'h0}))
      else $error("bank not at reset values");
   a_upper_zero: assert property (ctrl.sysCtrl[31:16] == 16'h0)
      else $error("control upper half not zero");
   a_start_held: assert property (sCkStart |-> ctrl.sysCtrl[13] [*8])
      else $error("start bit dropped early");
   a_start_ends: assert property (sCkStart |-> ##[1:600] sCkEnd)
      else $error("checksum never finished");
   a_result_moves: assert property ($changed(ctrl.sysCtrl[15]) |-> sCkEnd)
      else $error("result changed outside completion");
   a_lock_freeze: assert property (sLocked |=> $stable(ctrl.sysCtrl[14]))
      else $error("debug bit changed while locked");
   a_unmapped_read: assert property (sRdTake and !mapped(axiReq.araddr) |=> axiRsp.rvalid && axiRsp.rresp == 2'h2 && axiRsp.rdata == 32'h0)
      else $error("unmapped read not refused");
   a_clock_regs: assert property (sRdTake |=> ($past(axiReq.araddr) != 8'h18 || axiRsp.rdata == $past(ctrl.pclkDiv)) && ($past(axiReq.araddr) != 8'h24 || axiRsp.rdata == $past(ctrl.pclkGate0)) && ($past(axiReq.araddr) != 8'h48 || axiRsp.rdata == $past(ctrl.pclkGate1)))
      else $error("clock register read wrong");
endmodule // gcb_bank_asserts

bind gcb_bank gcb_bank_asserts #(.ROM_AW(ROM_AW)) i_gcb_bank_asserts (.mclk(mclk), .rst_b(rst_b),
   .ce(ce), .axiReq(axiReq), .axiRsp(axiRsp), .debugLockPin(debugLockPin), .romData(romData),
   .romAddr(romAddr), .ctrl(ctrl), .irq(irq));

// ===== tb/tb_gcb_bank.sv
// Self-checking bench of the global control bank.
`timescale 1ns/1ps
module tb_gcb_bank import gcb_pkg::*; ;
   localparam int AW = 4;
   localparam logic [31:0] SUM = 32'h0000_07F8;
   localparam logic [31:0] REV = 32'h0000_005C; // Arbitrary value.
   localparam logic [7:0] OFS [10] = '{8'h04, 8'h08, 8'h0C, 8'h18, 8'h24, 8'h28, 8'h2C, 8'h44,
      8'h48, 8'h4C};
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic lockPin = 1'b0;
   logic ce = 1'b1;
   logic [31:0] romBias = 32'h0;
   gcb_axi_req_t axiReq = '0;
   gcb_axi_rsp_t axiRsp;
   logic [AW-1:0] romAddr;
   logic [31:0] romData;
   gcb_ctrl_t ctrl;
   logic irq;
   int badCount = 0;
   int comparisons = 0;
   logic [1:0] resp;
   logic [31:0] rd;
   always #2 mclk = ~mclk;
   // A bias of one breaks the sum, so the same ROM serves both outcomes.
   assign romData = {28'h0, romAddr} * 32'h0000_0011 + romBias;
   gcb_bank #(.ROM_AW(AW), .EXPECTED_SUM(SUM), .REVISION(REV)) i_gcb_bank (.mclk(mclk),
      .rst_b(rst_b), .ce(ce), .axiReq(axiReq), .axiRsp(axiRsp), .debugLockPin(lockPin),
      .romData(romData), .romAddr(romAddr), .ctrl(ctrl), .irq(irq));
   // ****************************************
   // Bus cycles and comparison
   // ****************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         badCount++;
         $display("CHECK FAILED at %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task complete_run;
      if (badCount == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic axWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge mclk);
      axiReq <= '{awvalid: 1, awaddr: a, wvalid: 1, wdata: d, wstrb: 4'hF, bready: 1, default: 0};
      for (n = 0; n < 50; n++) begin
         @(posedge mclk);
         if (axiRsp.awready) axiReq.awvalid <= 1'b0;
         if (axiRsp.wready) axiReq.wvalid <= 1'b0;
         if (axiRsp.bvalid) break;
      end
      r = axiRsp.bresp;
      axiReq.bready <= 1'b0;
      if (n == 50) begin
         badCount++;
         complete_run();
      end
   endtask
   task automatic axRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge mclk);
      axiReq <= '{arvalid: 1, araddr: a, rready: 1, default: 0};
      for (n = 0; n < 50; n++) begin
         @(posedge mclk);
         if (axiRsp.arready) axiReq.arvalid <= 1'b0;
         if (axiRsp.rvalid) break;
      end
      d = axiRsp.rdata;
      r = axiRsp.rresp;
      axiReq.rready <= 1'b0;
      if (n == 50) begin
         badCount++;
         complete_run();
      end
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      axRead(a, rd, resp);
      chk(rd, exp);
      chk({30'h0, resp}, 32'h0);
   endtask
   task automatic wrOk(input logic [7:0] a, input logic [31:0] d);
      axWrite(a, d, resp);
      chk({30'h0, resp}, 32'h0);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic scnReset;
      rdChk(8'h00, 32'h0000_0002);
      rdChk(8'h50, REV);
      rdChk(8'h40, 32'h0);
      rdChk(8'h54, 32'h0);
   endtask
   task automatic scnStorage;
      int i;
      for (i = 0; i < 10; i++) begin
         wrOk(OFS[i], 32'hA5C3_0000 + 32'(i));
         rdChk(OFS[i], 32'hA5C3_0000 + 32'(i));
      end
      chk(ctrl.pclkDiv, 32'hA5C3_0003);
      chk(ctrl.pclkGate0, 32'hA5C3_0004);
      chk(ctrl.pclkGate1, 32'hA5C3_0008);
      chk(ctrl.sysCtrl, 32'h0000_0002);
      axWrite(8'h30, 32'hFFFF_FFFF, resp);
      chk({30'h0, resp}, 32'h2);
      axRead(8'h41, rd, resp);
      chk(rd, 32'h0);
      chk({30'h0, resp}, 32'h2);
   endtask
   task automatic scnSysCtrl;
      wrOk(8'h00, 32'hFFFF_DFFF);
      rdChk(8'h00, 32'h0000_4026);
      lockPin <= 1'b1;
      repeat (5) @(posedge mclk);
      rdChk(8'h40, 32'h0000_0001);
      wrOk(8'h00, 32'h0000_0002);
      rdChk(8'h00, 32'h0000_4002);
      lockPin <= 1'b0;
      repeat (5) @(posedge mclk);
      wrOk(8'h00, 32'h0000_0002);
      rdChk(8'h00, 32'h0000_0002);
   endtask
   task automatic scnChecksum(input logic [31:0] bias, input logic fail);
      int n;
      romBias <= bias;
      wrOk(8'h54, 32'h0000_0006);
      wrOk(8'h00, 32'h0000_2002);
      wrOk(8'h00, 32'h0000_0002);
      rdChk(8'h00, 32'h0000_2002);
      // A frozen clock enable must stall the sum well past its normal length.
      ce <= 1'b0;
      repeat (30) @(posedge mclk);
      chk({31'h0, ctrl.sysCtrl[13]}, 32'h1);
      ce <= 1'b1;
      for (n = 0; n < 40; n++) begin
         axRead(8'h00, rd, resp);
         if (rd[13] === 1'b0) break;
      end
      if (n == 40) begin
         badCount++;
         complete_run();
      end
      chk(rd, {16'h0, fail, 15'h0002});
      chk({28'h0, romAddr}, 32'h0000_000F);
      rdChk(8'h40, {29'h0, fail, 2'b10});
      chk({31'h0, irq}, 32'h1);
      wrOk(8'h54, 32'h0);
      @(posedge mclk);
      chk({31'h0, irq}, 32'h0);
      wrOk(8'h54, 32'h0000_0006);
      wrOk(8'h40, 32'h0000_0006);
      rdChk(8'h40, 32'h0);
      chk({31'h0, irq}, 32'h0);
   endtask
   initial begin
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      scnReset();
      scnStorage();
      scnSysCtrl();
      scnChecksum(32'h0, 1'b0);
      scnChecksum(32'h1, 1'b1);
      @(posedge mclk);
      rst_b <= 1'b0;
      @(posedge mclk);
      rst_b <= 1'b1;
      rdChk(8'h18, 32'h0);
      rdChk(8'h00, 32'h0000_0002);
      complete_run();
   end
endmodule // tb_gcb_bank
